// ### logic/bdms_core.v
`timescale 1ns/1ns
`default_nettype none
`include "bdms_defines.vh"

// Summary of operation
// - Flags register bits 7 to 5 read zero and ignore writes.
// - Time-out flag set by power-up, watchdog clear, sleep; cleared by time-out.
// - Power-down flag set by power-up or watchdog clear; cleared by sleep.
// - Zero flag follows whether an add, subtract or logic result is all zero.
// - Digit carry flag is the carry out of result bit 3.
// - Carry flag is the carry out of the top result bit.
// - Subtraction adds the two's complement; carries act as inverted borrows.
// - Rotates load carry with the bit shifted out of the source.
// - Time-out, power-down read-only, one at power-on; arithmetic flags zero there.
// - Each bank holds eighty bytes of general purpose RAM.
// - General RAM is also reachable linearly through the pointers.
// - Sixteen common RAM bytes appear identically in every bank.
// - Offsets 00-0B core, 0C-1F special, 20-6F general, 70-7F common.
// - Flag-updating operation suppresses data writes to the three arithmetic flags.
// - Bank select register picks one of thirty-two 128-byte banks.
// - Unimplemented locations read as zero.
module bdms_core (
    input  wire                   ref_clk,
    input  wire                   rst_n,
    input  wire                   other_rst_n,
    input  wire                   acc_valid,
    input  wire                   acc_write,
    input  wire [6:0]             acc_offset,
    input  wire [7:0]             acc_wdata,
    output reg  [7:0]             acc_rdata_reg,
    output reg                    acc_rvalid_reg,
    input  wire                   alu_valid,
    input  wire [2:0]             alu_op,
    input  wire [7:0]             alu_a,
    input  wire [7:0]             alu_b,
    output reg  [7:0]             alu_result_reg,
    input  wire                   watchdog_clear_instr,
    input  wire                   sleep_instr,
    input  wire                   watchdog_timer_timeout,
    output reg  [4:0]             flags_reg,
    output reg  [`BDMS_BANK_W-1:0] bank_select_reg,
    output reg  [7:0]             working_accumulator_reg
);

    // Core registers
    reg  [7:0]  program_counter_low_reg;
    reg  [7:0]  pointer0_low_reg;
    reg  [7:0]  pointer0_high_reg;
    reg  [7:0]  pointer1_low_reg;
    reg  [7:0]  pointer1_high_reg;
    reg  [7:0]  program_counter_latch_high_reg;
    reg  [7:0]  interrupt_control_reg;

    // Read pipeline
    reg         p1_valid_reg;
    reg  [1:0]  p1_kind_reg;
    reg  [7:0]  p1_core_reg;

    reg  [4:0]  flags_next;
    reg  [7:0]  core_rdata;
    reg  [9:0]  alu_out;
    wire [13:0] target;
    wire [1:0]  tgt_kind;
    wire [11:0] tgt_idx;
    wire        is_ind;
    wire [15:0] ptr_sel;
    wire        core_we;
    wire        ram_we;
    wire [7:0]  ram_rdata;
    wire        core_rst;
    wire        flags_data_we;

    // First RAM index of a bank, eighty general bytes per bank
    function [11:0] bdms_bank_base;
        input [4:0] bank;
        begin
            bdms_bank_base = {1'b0, bank, 6'h00} + {3'h0, bank, 4'h0};
        end
    endfunction

    // Banked address to access kind and RAM index
    function [13:0] bdms_map;
        input [11:0] addr;
        reg   [6:0]  off;
        reg   [4:0]  bank;
        begin
            off  = addr[6:0];
            bank = addr[11:7];
            if (off < `BDMS_SFR_BASE) begin
                bdms_map = {`BDMS_KIND_CORE, 5'h00, off};
            end else if (off < `BDMS_GPR_BASE) begin
                bdms_map = {`BDMS_KIND_NONE, 12'h000};
            end else if (off < `BDMS_COM_BASE) begin
                // Bank base plus offset inside the general region
                bdms_map = {`BDMS_KIND_RAM, bdms_bank_base(bank)
                            + {5'h00, off} - `BDMS_GPR_OFS};
            end else begin
                bdms_map = {`BDMS_KIND_RAM,
                            `BDMS_COM_IDX + {8'h00, off[3:0]}};
            end
        end
    endfunction

    // Resolve direct or pointer access
    function [13:0] bdms_resolve;
        input        ind;
        input [15:0] ptr;
        input [11:0] daddr;
        reg   [13:0] m;
        begin
            m = bdms_map(ptr[11:0]);
            if (!ind) begin
                bdms_resolve = bdms_map(daddr);
            end else if (ptr < `BDMS_TRAD_END) begin
                // Indirect data through a pointer holds no data
                if (m[13:12] == `BDMS_KIND_CORE && m[6:1] == 6'h00) begin
                    bdms_resolve = {`BDMS_KIND_NONE, 12'h000};
                end else begin
                    bdms_resolve = m;
                end
            end else if (ptr[15]) begin
                // Program memory is not served here and reads as zero
                bdms_resolve = {`BDMS_KIND_NONE, 12'h000};
            end else if (ptr >= `BDMS_LIN_BASE && ptr < `BDMS_LIN_END) begin
                bdms_resolve = {`BDMS_KIND_RAM, ptr[11:0]};
            end else begin
                bdms_resolve = {`BDMS_KIND_NONE, 12'h000};
            end
        end
    endfunction

    // Operation result with digit carry and carry
    function [9:0] bdms_alu;
        input [2:0] op;
        input [7:0] a;
        input [7:0] b;
        input       cin;
        reg   [8:0] sum;
        reg   [4:0] nib;
        begin
            sum = 9'h000;
            nib = 5'h00;
            bdms_alu = 10'h000;
            case (op)
                `BDMS_OP_ADD: begin
                    sum = {1'b0, a} + {1'b0, b};
                    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                    bdms_alu = {sum[8], nib[4], sum[7:0]};
                end
                `BDMS_OP_SUB: begin
                    sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
                    nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
                    bdms_alu = {sum[8], nib[4], sum[7:0]};
                end
                `BDMS_OP_AND: bdms_alu = {cin, 1'b0, a & b};
                `BDMS_OP_IOR: bdms_alu = {cin, 1'b0, a | b};
                `BDMS_OP_XOR: bdms_alu = {cin, 1'b0, a ^ b};
                `BDMS_OP_RRF: begin
                    bdms_alu = {a[0], 1'b0, cin, a[7:1]};
                end
                `BDMS_OP_RLF: begin
                    bdms_alu = {a[7], 1'b0, a[6:0], cin};
                end
                default: bdms_alu = {cin, 1'b0, a};
            endcase
        end
    endfunction

    // Offsets 0 and 1 go through the matching pointer
    assign is_ind  = (acc_offset[6:1] == 6'h00);
    assign ptr_sel = acc_offset[0] ? {pointer1_high_reg, pointer1_low_reg}
                                   : {pointer0_high_reg, pointer0_low_reg};
    assign target  = bdms_resolve(is_ind, ptr_sel,
                                  {bank_select_reg, acc_offset});
    assign tgt_kind = target[13:12];
    assign tgt_idx  = target[11:0];
    assign core_we  = acc_valid & acc_write & (tgt_kind == `BDMS_KIND_CORE);
    assign ram_we   = acc_valid & acc_write & (tgt_kind == `BDMS_KIND_RAM);

    // Any reset clears the core registers other than flags, and the read pipeline
    assign core_rst = !rst_n || !other_rst_n;

    // Flags take a data write only when no operation updates them too
    assign flags_data_we = core_we & (tgt_idx[6:0] == `BDMS_OFS_FLAGS)
                           & ~alu_valid;

    // General and common RAM
    bdms_ram u_ram (
        .ref_clk   (ref_clk),
        .we        (ram_we),
        .addr      (tgt_idx),
        .wdata     (acc_wdata),
        .rdata_reg (ram_rdata)
    );

    // Core register read mux, decoded per offset
    always @* begin
        case (tgt_idx[6:0])
            `BDMS_OFS_PCL:     core_rdata = program_counter_low_reg;
            `BDMS_OFS_FLAGS:   core_rdata = {3'h0, flags_reg};
            `BDMS_OFS_PTR0_LO: core_rdata = pointer0_low_reg;
            `BDMS_OFS_PTR0_HI: core_rdata = pointer0_high_reg;
            `BDMS_OFS_PTR1_LO: core_rdata = pointer1_low_reg;
            `BDMS_OFS_PTR1_HI: core_rdata = pointer1_high_reg;
            `BDMS_OFS_BANK:    core_rdata = {3'h0, bank_select_reg};
            `BDMS_OFS_WORKING_ACCUMULATOR:    core_rdata = working_accumulator_reg;
            `BDMS_OFS_PROGRAM_COUNTER_LATCH_HIGH:  core_rdata = program_counter_latch_high_reg;
            `BDMS_OFS_INTERRUPT_CONTROL:  core_rdata = interrupt_control_reg;
            default:           core_rdata = 8'h00;
        endcase
    end

    // Operation outcome
    always @* begin
        alu_out = bdms_alu(alu_op, alu_a, alu_b, flags_reg[`BDMS_BIT_C]);
    end

    // Flag update: data write, then operation, then events
    always @* begin
        flags_next = flags_reg;
        if (flags_data_we) begin
            flags_next[2:0] = acc_wdata[2:0];
        end
        if (alu_valid) begin
            case (alu_op)
                `BDMS_OP_ADD, `BDMS_OP_SUB: begin
                    flags_next[`BDMS_BIT_Z]  = (alu_out[7:0] == 8'h00);
                    flags_next[`BDMS_BIT_DC] = alu_out[8];
                    flags_next[`BDMS_BIT_C]  = alu_out[9];
                end
                `BDMS_OP_AND, `BDMS_OP_IOR, `BDMS_OP_XOR: begin
                    flags_next[`BDMS_BIT_Z] = (alu_out[7:0] == 8'h00);
                end
                `BDMS_OP_RRF, `BDMS_OP_RLF: begin
                    flags_next[`BDMS_BIT_C] = alu_out[9];
                end
                default: begin
                    flags_next[`BDMS_BIT_Z] = flags_reg[`BDMS_BIT_Z];
                end
            endcase
        end
        if (watchdog_clear_instr) begin
            flags_next[`BDMS_BIT_TO] = 1'b1;
            flags_next[`BDMS_BIT_PD] = 1'b1;
        end
        if (sleep_instr) begin
            flags_next[`BDMS_BIT_TO] = 1'b1;
            flags_next[`BDMS_BIT_PD] = 1'b0;
        end
        if (watchdog_timer_timeout) begin
            flags_next[`BDMS_BIT_TO] = 1'b0;
        end
    end

    // Arithmetic flags keep their value across resets other than power-on
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            flags_reg <= `BDMS_FLAGS_POR;
        end else if (other_rst_n) begin
            flags_reg <= flags_next;
        end else begin
            // Status events still land while the other reset is held
            flags_reg <= {flags_next[4:3], flags_reg[2:0]};
        end
    end

    // Core register writes, flags handled above
    always @(posedge ref_clk) begin
        if (core_rst) begin
            program_counter_low_reg        <= 8'h00;
            pointer0_low_reg               <= 8'h00;
            pointer0_high_reg              <= 8'h00;
            pointer1_low_reg               <= 8'h00;
            pointer1_high_reg              <= 8'h00;
            bank_select_reg                <= 5'h00;
            working_accumulator_reg        <= 8'h00;
            program_counter_latch_high_reg <= 8'h00;
            interrupt_control_reg          <= 8'h00;
        end else if (core_we) begin
            case (tgt_idx[6:0])
                `BDMS_OFS_PCL:     program_counter_low_reg <= acc_wdata;
                `BDMS_OFS_PTR0_LO: pointer0_low_reg <= acc_wdata;
                `BDMS_OFS_PTR0_HI: pointer0_high_reg <= acc_wdata;
                `BDMS_OFS_PTR1_LO: pointer1_low_reg <= acc_wdata;
                `BDMS_OFS_PTR1_HI: pointer1_high_reg <= acc_wdata;
                `BDMS_OFS_BANK: begin
                    bank_select_reg <= acc_wdata[4:0];
                end
                `BDMS_OFS_WORKING_ACCUMULATOR:    working_accumulator_reg <= acc_wdata;
                `BDMS_OFS_PROGRAM_COUNTER_LATCH_HIGH:  program_counter_latch_high_reg <= acc_wdata;
                `BDMS_OFS_INTERRUPT_CONTROL:  interrupt_control_reg <= acc_wdata;
                default: begin
                    interrupt_control_reg <= interrupt_control_reg;
                end
            endcase
        end
    end

    // Operation result register
    always @(posedge ref_clk) begin
        if (core_rst) begin
            alu_result_reg <= 8'h00;
        end else if (alu_valid) begin
            alu_result_reg <= alu_out[7:0];
        end
    end

    // Read stage 1: capture kind and core value
    always @(posedge ref_clk) begin
        if (core_rst) begin
            p1_valid_reg <= 1'b0;
            p1_kind_reg  <= `BDMS_KIND_NONE;
            p1_core_reg  <= 8'h00;
        end else begin
            p1_valid_reg <= acc_valid & ~acc_write;
            p1_kind_reg  <= tgt_kind;
            p1_core_reg  <= core_rdata;
        end
    end

    // Read stage 2: present read data, held until the next answer
    always @(posedge ref_clk) begin
        if (core_rst) begin
            acc_rvalid_reg <= 1'b0;
            acc_rdata_reg  <= 8'h00;
        end else begin
            acc_rvalid_reg <= p1_valid_reg;
            if (p1_valid_reg) begin
                case (p1_kind_reg)
                    `BDMS_KIND_RAM:  acc_rdata_reg <= ram_rdata;
                    `BDMS_KIND_CORE: acc_rdata_reg <= p1_core_reg;
                    default:         acc_rdata_reg <= 8'h00;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ### logic/bdms_defines.vh
`ifndef BDMS_DEFINES_VH
`define BDMS_DEFINES_VH

// Core register offsets inside every bank
`define BDMS_OFS_IND0      7'h00
`define BDMS_OFS_IND1      7'h01
`define BDMS_OFS_PCL       7'h02
`define BDMS_OFS_FLAGS     7'h03
`define BDMS_OFS_PTR0_LO   7'h04
`define BDMS_OFS_PTR0_HI   7'h05
`define BDMS_OFS_PTR1_LO   7'h06
`define BDMS_OFS_PTR1_HI   7'h07
`define BDMS_OFS_BANK      7'h08
`define BDMS_OFS_WORKING_ACCUMULATOR      7'h09
`define BDMS_OFS_PROGRAM_COUNTER_LATCH_HIGH    7'h0A
`define BDMS_OFS_INTERRUPT_CONTROL    7'h0B

// Region bounds of the 7-bit bank offset
`define BDMS_SFR_BASE      7'h0C
`define BDMS_GPR_BASE      7'h20
`define BDMS_COM_BASE      7'h70

// Physical RAM layout: 32 banks of 80 general bytes, then 16 common
`define BDMS_GPR_BYTES     80
`define BDMS_COM_BYTES     16
`define BDMS_BANKS         32
`define BDMS_RAM_DEPTH     2576
`define BDMS_RAM_AW        12
`define BDMS_COM_IDX       12'hA00
`define BDMS_GPR_OFS       12'h020

// Pointer address windows
`define BDMS_TRAD_END      16'h1000
`define BDMS_LIN_BASE      16'h2000
`define BDMS_LIN_END       16'h2A00

// Flag bit positions and reset values
`define BDMS_BIT_C         0
`define BDMS_BIT_DC        1
`define BDMS_BIT_Z         2
`define BDMS_BIT_PD        3
`define BDMS_BIT_TO        4
`define BDMS_FLAGS_POR     5'h18
`define BDMS_BANK_W        5

// Decoded access kinds
`define BDMS_KIND_NONE     2'h0
`define BDMS_KIND_CORE     2'h1
`define BDMS_KIND_RAM      2'h2

// Arithmetic and logic operation codes
`define BDMS_OP_ADD        3'h0
`define BDMS_OP_SUB        3'h1
`define BDMS_OP_AND        3'h2
`define BDMS_OP_IOR        3'h3
`define BDMS_OP_XOR        3'h4
`define BDMS_OP_RRF        3'h5
`define BDMS_OP_RLF        3'h6

`endif

// ### logic/bdms_ram.v
`timescale 1ns/1ns
`default_nettype none
`include "bdms_defines.vh"

module bdms_ram (
    input  wire                    ref_clk,
    input  wire                    we,
    input  wire [`BDMS_RAM_AW-1:0] addr,
    input  wire [7:0]              wdata,
    output reg  [7:0]              rdata_reg
);

    reg [7:0] mem [0:`BDMS_RAM_DEPTH-1];

    // Single port, read data registered, old data on a write
    always @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_reg <= mem[addr];
    end

endmodule

`default_nettype wire

// ### verification/bdms_core_chk.sv
`timescale 1ns/1ns
`default_nettype none
// Timing and flag relations seen at the core's ports
module bdms_core_chk (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       other_rst_n,
    input wire logic       acc_valid,
    input wire logic       acc_write,
    input wire logic [6:0] acc_offset,
    input wire logic [7:0] acc_wdata,
    input wire logic [7:0] acc_rdata_reg,
    input wire logic       acc_rvalid_reg,
    input wire logic       alu_valid,
    input wire logic [2:0] alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic [7:0] alu_result_reg,
    input wire logic       watchdog_clear_instr,
    input wire logic       sleep_instr,
    input wire logic       watchdog_timer_timeout,
    input wire logic [4:0] flags_reg,
    input wire logic [4:0] bank_select_reg,
    input wire logic [7:0] working_accumulator_reg
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !other_rst_n);

    // Read answer two cycles after the request, never otherwise
    a_read_latency: assert property (acc_valid && !acc_write |-> ##2
        acc_rvalid_reg) else $error("read answer late");
    a_read_cause: assert property (acc_rvalid_reg |->
        $past(acc_valid && !acc_write, 2)) else $error("stray read answer");
    a_rdata_hold: assert property (!acc_rvalid_reg |->
        $stable(acc_rdata_reg)) else $error("read data moved");
    // Arithmetic and rotate flag results
    a_zero_flag: assert property (alu_valid && alu_op < 3'h5 |=>
        flags_reg[2] == (alu_result_reg == 8'h00)) else $error("zero flag");
    a_add_carry: assert property (alu_valid && alu_op == 3'h0 |=>
        {flags_reg[0], alu_result_reg} == {1'b0, $past(alu_a)} + $past(alu_b))
        else $error("add carry");
    a_digit_carry: assert property (alu_valid && alu_op == 3'h0 |=>
        flags_reg[1] == ({1'b0, $past(alu_a[3:0])} + $past(alu_b[3:0]) > 5'h0F))
        else $error("digit carry");
    a_sub_borrow: assert property (alu_valid && alu_op == 3'h1 |=>
        alu_result_reg == $past(alu_a) - $past(alu_b) &&
        flags_reg[0] == ($past(alu_a) >= $past(alu_b))) else $error("borrow");
    a_rotate_right: assert property (alu_valid && alu_op == 3'h5 |=>
        {alu_result_reg, flags_reg[0]} == {$past(flags_reg[0]), $past(alu_a)})
        else $error("rotate right");
    a_rotate_left: assert property (alu_valid && alu_op == 3'h6 |=>
        {flags_reg[0], alu_result_reg} == {$past(alu_a), $past(flags_reg[0])})
        else $error("rotate left");
    // Reset status flags move only on their events; bank select takes the written value
    a_timeout_clear: assert property (watchdog_timer_timeout |=>
        !flags_reg[4]) else $error("time-out flag");
    a_sleep_pd: assert property (sleep_instr |=> flags_reg[4:3] ==
        {!$past(watchdog_timer_timeout), 1'b0}) else $error("sleep flags");
    a_status_hold: assert property (!(watchdog_clear_instr || sleep_instr ||
        watchdog_timer_timeout) |=> $stable(flags_reg[4:3]))
        else $error("status flags moved");
    a_bank_write: assert property (acc_valid && acc_write &&
        acc_offset == 7'h08 |=> bank_select_reg == $past(acc_wdata[4:0]))
        else $error("bank select");
endmodule
`default_nettype wire

// ### verification/bdms_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// Instruction datapath stand-in driving the core's request ports
module bdms_cpu_model (
    input  wire logic       ref_clk,
    input  wire logic       acc_rvalid_reg,
    input  wire logic [7:0] acc_rdata_reg,
    output var  logic       acc_valid,
    output var  logic       acc_write,
    output var  logic [6:0] acc_offset,
    output var  logic [7:0] acc_wdata,
    output var  logic       alu_valid,
    output var  logic [2:0] alu_op,
    output var  logic [7:0] alu_a,
    output var  logic [7:0] alu_b,
    output var  logic       watchdog_clear_instr,
    output var  logic       sleep_instr,
    output var  logic       watchdog_timer_timeout
);
    logic hung;

    // Quiet request lines at time zero
    initial begin
        hung = 1'b0;
        {acc_valid, acc_write, acc_offset, acc_wdata} = 17'h00000;
        {alu_valid, alu_op, alu_a, alu_b} = 20'h00000;
        {watchdog_clear_instr, sleep_instr, watchdog_timer_timeout} = 3'h0;
    end

    task step;
        @(posedge ref_clk);
        #1;
    endtask

    // Drop strobes; data and operand lines show the inverse of their last value
    task idle;
        {acc_valid, alu_valid} = 2'h0;
        {watchdog_clear_instr, sleep_instr, watchdog_timer_timeout} = 3'h0;
        acc_wdata = ~acc_wdata;
        alu_a = ~alu_a;
        alu_b = ~alu_b;
    endtask

    task req(input logic w, input logic [6:0] o, input logic [7:0] d);
        acc_valid = 1'b1;
        acc_write = w;
        acc_offset = o;
        acc_wdata = d;
    endtask

    task op(input logic [2:0] c, input logic [7:0] a, input logic [7:0] b);
        alu_valid = 1'b1;
        alu_op = c;
        alu_a = a;
        alu_b = b;
    endtask

    task ev(input logic [2:0] v);
        {watchdog_clear_instr, sleep_instr, watchdog_timer_timeout} = v;
        step;
    endtask

    // One-cycle read request, answer awaited under a bound
    task rd(input logic [6:0] o, output logic [7:0] d);
        integer n;
        req(1'b0, o, ~acc_wdata);
        step;
        acc_valid = 1'b0;
        d = 8'hXX;
        hung = 1'b1;
        for (n = 0; n < 4 && hung; n = n + 1) begin
            step;
            if (acc_rvalid_reg === 1'b1) begin
                d = acc_rdata_reg;
                hung = 1'b0;
            end
        end
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the banked memory and flags core
module testbench;
    logic       ref_clk, rst_n, other_rst_n;
    wire        acc_valid, acc_write, acc_rvalid_reg, alu_valid;
    wire        watchdog_clear_instr, sleep_instr, watchdog_timer_timeout;
    wire  [6:0] acc_offset;
    wire  [2:0] alu_op;
    wire  [4:0] flags_reg, bank_select_reg;
    wire  [7:0] acc_wdata, acc_rdata_reg, alu_a, alu_b, alu_result_reg;
    wire  [7:0] working_accumulator_reg;
    integer     mismatches, check_count;
    logic [7:0] rv;

    bdms_core uut (.*);
    bdms_cpu_model cpu (.*);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task conclude;
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count = check_count + 1;
        if (cpu.hung !== 1'b0) begin
            mismatches = mismatches + 1;
            $display("Error %s expected read answer seen timeout", nm);
            conclude;
        end
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task wr(input logic [6:0] o, input logic [7:0] d);
        cpu.req(1'b1, o, d);
        cpu.step;
    endtask

    task rdc(input string nm, input logic [6:0] o, input logic [7:0] exp);
        cpu.rd(o, rv);
        chk(nm, exp, rv);
    endtask

    task alu_chk(input logic [2:0] c, input logic [7:0] a, input logic [7:0] b,
                 input logic [7:0] res, input logic [2:0] fl);
        cpu.op(c, a, b);
        cpu.step;
        chk("result", res, alu_result_reg);
        chk("arith flags", {5'h00, fl}, {5'h00, flags_reg[2:0]});
    endtask

    // Flag register bits, reset value and suppressed data write
    task t_flags;
        rdc("flags", 7'h03, 8'h18);
        wr(7'h03, 8'hFF);
        rdc("flags", 7'h03, 8'h1F);
        cpu.op(3'h0, 8'h01, 8'h01);
        cpu.req(1'b1, 7'h03, 8'h07);
        cpu.step;
        cpu.idle;
        rdc("flags", 7'h03, 8'h18);
        $display("t_flags done");
    endtask

    // Every operation code back to back
    task t_alu;
        alu_chk(3'h0, 8'hF8, 8'h08, 8'h00, 3'b111);
        alu_chk(3'h1, 8'h05, 8'h06, 8'hFF, 3'b000);
        alu_chk(3'h2, 8'hF0, 8'h0F, 8'h00, 3'b100);
        alu_chk(3'h3, 8'hA0, 8'h05, 8'hA5, 3'b000);
        alu_chk(3'h4, 8'h5A, 8'h5A, 8'h00, 3'b100);
        alu_chk(3'h5, 8'h81, 8'h00, 8'h40, 3'b101);
        alu_chk(3'h6, 8'h80, 8'h00, 8'h01, 3'b101);
        alu_chk(3'h1, 8'h30, 8'h2F, 8'h01, 3'b001);
        cpu.idle;
        $display("t_alu done");
    endtask

    // Banks, common bytes, regions and linear pointer access
    task t_mem;
        wr(7'h08, 8'h00);
        wr(7'h20, 8'hA1);
        wr(7'h6F, 8'hA2);
        wr(7'h70, 8'hA3);
        wr(7'h08, 8'h1F);
        wr(7'h20, 8'hB1);
        rdc("common", 7'h70, 8'hA3);
        rdc("bank31", 7'h20, 8'hB1);
        chk("bank", 8'h1F, {3'h0, bank_select_reg});
        rdc("mirror", 7'h03, 8'h19);
        wr(7'h09, 8'h3C);
        chk("accum", 8'h3C, working_accumulator_reg);
        wr(7'h0C, 8'h55);
        rdc("special", 7'h0C, 8'h00);
        wr(7'h04, 8'hB0);
        wr(7'h05, 8'h29);
        rdc("linear", 7'h00, 8'hB1);
        wr(7'h06, 8'h4F);
        wr(7'h07, 8'h20);
        rdc("linear", 7'h01, 8'hA2);
        wr(7'h00, 8'hC4);
        rdc("direct", 7'h20, 8'hC4);
        wr(7'h08, 8'h00);
        rdc("bank0", 7'h20, 8'hA1);
        rdc("bank0", 7'h6F, 8'hA2);
        wr(7'h0B, 8'h5A);
        rdc("core top", 7'h0B, 8'h5A);
        wr(7'h1F, 8'h66);
        rdc("special top", 7'h1F, 8'h00);
        wr(7'h05, 8'h30);
        rdc("unmapped", 7'h00, 8'h00);
        $display("t_mem done");
    endtask

    // Status events alone and together, then the other reset
    task t_events;
        cpu.ev(3'b001);
        chk("status", 8'h01, {6'h00, flags_reg[4:3]});
        cpu.ev(3'b010);
        chk("status", 8'h02, {6'h00, flags_reg[4:3]});
        cpu.ev(3'b100);
        chk("status", 8'h03, {6'h00, flags_reg[4:3]});
        cpu.ev(3'b101);
        chk("status", 8'h01, {6'h00, flags_reg[4:3]});
        cpu.ev(3'b110);
        chk("status", 8'h02, {6'h00, flags_reg[4:3]});
        cpu.idle;
        wr(7'h08, 8'h07);
        chk("bank", 8'h07, {3'h0, bank_select_reg});
        cpu.idle;
        other_rst_n = 1'b0;
        cpu.step;
        cpu.step;
        other_rst_n = 1'b1;
        chk("flags held", 8'h11, {3'h0, flags_reg});
        chk("bank reset", 8'h00, {3'h0, bank_select_reg});
        cpu.step;
        other_rst_n = 1'b0;
        cpu.ev(3'b001);
        cpu.idle;
        other_rst_n = 1'b1;
        chk("reset timeout", 8'h01, {3'h0, flags_reg});
        $display("t_events done");
    endtask

    initial begin
        mismatches = 0;
        check_count = 0;
        rst_n = 1'b0;
        other_rst_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_flags;
        t_alu;
        t_mem;
        t_events;
        conclude;
    end
endmodule

bind bdms_core bdms_core_chk u_chk (.*);
`default_nettype wire
